// *** rtl/spi_ctrl_pkg.sv ***
// Shared constants and register layouts for the serial peripheral control block.
package spi_ctrl_pkg;

	// Register bus geometry.
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;

	// Register byte offsets.
	localparam logic [7:0] CTRL_A_OFFSET = 8'h00;
	localparam logic [7:0] CTRL_B_OFFSET = 8'h04;
	localparam logic [7:0] STATUS_OFFSET = 8'h08;
	localparam logic [7:0] DATA_OFFSET = 8'h0C;

	// Reset values.
	localparam logic [15:0] CTRL_A_RESET = 16'h0000;
	localparam logic [15:0] CTRL_B_RESET = 16'h0000;
	localparam logic [15:0] DATA_RESET = 16'h0000;

	// Writable bits of the second control register; bits 15:9 and 4:3 stay zero.
	localparam logic [15:0] CTRL_B_WRITE_MASK = 16'h01E7;

	// Status register bit positions.
	localparam int STS_RX_FULL = 0;
	localparam int STS_TX_EMPTY = 1;
	localparam int STS_UNDERRUN = 3;
	localparam int STS_CRC = 4;
	localparam int STS_MODE_FAULT = 5;
	localparam int STS_OVERFLOW = 6;
	localparam int STS_BUSY = 7;

	// Prescaler geometry: code 9 divides by 1024, half period 512 clocks.
	localparam int PRESCALE_W = 4;
	localparam logic [3:0] PRESCALE_MAX = 4'h9;
	localparam int DIV_COUNT_W = 10;

	// Default frame length in bits.
	localparam int FRAME_BITS = 8;

	typedef struct packed {
		logic [5:0] other_modes;
		logic soft_select_enable;
		logic soft_select_level;
		logic lsb_order_select;
		logic peripheral_on;
		logic [2:0] prescale_low;
		logic master_role_select;
		logic clock_idle_polarity;
		logic clock_capture_phase;
	} ctrl_a_t;

	typedef struct packed {
		logic [6:0] zero_bits;
		logic prescale_high;
		logic tx_empty_irq_enable;
		logic rx_full_irq_enable;
		logic error_irq_enable;
		logic [1:0] kept_bits;
		logic hard_select_output_enable;
		logic dma_tx_request_enable;
		logic dma_rx_request_enable;
	} ctrl_b_t;

endpackage

// *** rtl/spi_clock_divider.sv ***
// Half-period tick generator for the master serial clock.
`timescale 1ns/1ps
`default_nettype none
module spi_clock_divider
	import spi_ctrl_pkg::*;
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Control.
	input wire logic run_i,
	input wire logic [PRESCALE_W-1:0] code_i,
	// Tick out.
	output logic tick_o
);

	logic [DIV_COUNT_W-1:0] count;
	logic [DIV_COUNT_W:0] half_span;
	wire logic [DIV_COUNT_W-1:0] limit;

	// A serial period of 2^(code+1) clocks is two half periods of 2^code clocks.
	assign half_span = (DIV_COUNT_W+1)'(1) << code_i;
	assign limit = DIV_COUNT_W'(half_span - (DIV_COUNT_W+1)'(1));

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			count <= '0;
			tick_o <= 1'b0;
		end
		else if (!run_i)
		begin
			count <= '0;
			tick_o <= 1'b0;
		end
		else if (count == limit)
		begin
			count <= '0;
			tick_o <= 1'b1;
		end
		else
		begin
			count <= count + DIV_COUNT_W'(1);
			tick_o <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// *** rtl/spi_control.sv ***
// Serial peripheral control, configuration and frame engine.
//
// Overview of operation
// - Soft select enable takes select from software.
// - Soft select level sets effective select level.
// - Bit 7 picks MSB or LSB first.
// - Bit 6 switches interface on; reset off.
// - Master clock divides by two^(code+1).
// - Prescale code joins control A 5:3, B 8.
// - Bit 2 selects master role; reset slave.
// - Bit 1 sets serial clock idle level.
// - Bit 0 picks first or second capture edge.
// - Control B bits 15:9 read zero.
// - Transmit empty interrupt gated by bit 7.
// - Receive full interrupt gated by bit 6.
// - Error interrupt gates four error flags.
// - Hardware select output drives pin low.
// - Transmit empty flag reads one after reset.
//
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module spi_control
	import spi_ctrl_pkg::*;
#(
	parameter int FRAME_W = FRAME_BITS
)
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Register port.
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [DATA_W-1:0] rdata_o,
	// Error events from the checksum and audio logic.
	input wire logic crc_error_event_i,
	input wire logic tx_underrun_event_i,
	// Serial clock pin.
	input wire logic sck_i,
	output logic sck_o,
	output logic sck_oe_o,
	// Master-out data pin.
	input wire logic mosi_i,
	output logic mosi_o,
	output logic mosi_oe_o,
	// Master-in data pin.
	input wire logic miso_i,
	output logic miso_o,
	output logic miso_oe_o,
	// Chip select pin.
	input wire logic cs_i,
	output logic cs_o,
	output logic cs_oe_o,
	// Interrupt and DMA requests.
	output logic tx_empty_irq_o,
	output logic rx_full_irq_o,
	output logic error_irq_o,
	output logic dma_tx_req_o,
	output logic dma_rx_req_o
);

	localparam int EDGE_W = $clog2(2 * FRAME_W);
	localparam int CAP_W = $clog2(FRAME_W) + 1;
	localparam logic [EDGE_W-1:0] LAST_EDGE = EDGE_W'(2 * FRAME_W - 1);

	logic rst_meta;
	logic rst_sync_n;
	logic [3:0] pin_meta;
	logic [3:0] pin_sync;
	logic sck_prev;
	ctrl_a_t ctrl_a;
	ctrl_b_t ctrl_b;
	logic [FRAME_W-1:0] tx_buf;
	logic [FRAME_W-1:0] rx_buf;
	logic [FRAME_W-1:0] shreg;
	logic tx_empty;
	logic rx_full;
	logic overflow;
	logic mode_fault;
	logic crc_flag;
	logic underrun;
	logic fault_read_armed;
	logic busy;
	logic sck_level;
	logic out_bit;
	logic [EDGE_W-1:0] edge_cnt;
	logic div_tick;

	// Synchronised pins: {sck, mosi, miso, cs}.
	wire logic sck_s = pin_sync[3];
	wire logic mosi_s = pin_sync[2];
	wire logic miso_s = pin_sync[1];
	wire logic cs_s = pin_sync[0];

	// Register decode.
	wire logic hit_a = addr_i == CTRL_A_OFFSET;
	wire logic hit_b = addr_i == CTRL_B_OFFSET;
	wire logic hit_sts = addr_i == STATUS_OFFSET;
	wire logic hit_data = addr_i == DATA_OFFSET;
	wire logic wr_a = wr_i & hit_a;
	wire logic wr_b = wr_i & hit_b;
	wire logic wr_sts = wr_i & hit_sts;
	wire logic wr_data = wr_i & hit_data;
	wire logic rd_sts = rd_i & hit_sts;
	wire logic rd_data = rd_i & hit_data;

	// Effective select level and roles.
	wire logic eff_cs = ctrl_a.soft_select_enable ? ctrl_a.soft_select_level : cs_s;
	wire logic on = ctrl_a.peripheral_on;
	wire logic is_master = on & ctrl_a.master_role_select;
	wire logic slave_sel = on & ~ctrl_a.master_role_select & ~eff_cs;
	wire logic fault_event = is_master & ~ctrl_b.hard_select_output_enable & ~eff_cs;

	// Prescale code, clamped to the largest documented divide.
	wire logic [3:0] code_raw = {ctrl_b.prescale_high, ctrl_a.prescale_low};
	wire logic [3:0] code = (code_raw > PRESCALE_MAX) ? PRESCALE_MAX : code_raw;

	// Edge detection for both roles.
	wire logic cpol = ctrl_a.clock_idle_polarity;
	wire logic edge_m = busy & is_master & div_tick;
	wire logic lead_m = edge_m & (sck_level == cpol);
	wire logic edge_s = busy & slave_sel & (sck_s != sck_prev);
	wire logic lead_s = edge_s & (sck_prev == cpol);
	wire logic edge_any = is_master ? edge_m : edge_s;
	wire logic lead_any = is_master ? lead_m : lead_s;
	wire logic capture = edge_any & (lead_any != ctrl_a.clock_capture_phase);
	wire logic drive = edge_any & ~capture;
	wire logic frame_end = edge_any & (edge_cnt == LAST_EDGE);

	// Shift data path.
	wire logic lsb = ctrl_a.lsb_order_select;
	wire logic data_in = is_master ? miso_s : mosi_s;
	wire logic [FRAME_W-1:0] shifted = lsb ? {data_in, shreg[FRAME_W-1:1]}
		: {shreg[FRAME_W-2:0], data_in};
	wire logic tx_bit = lsb ? shreg[0] : shreg[FRAME_W-1];
	wire logic [FRAME_W-1:0] load_word = tx_empty ? '0 : tx_buf;
	wire logic load_bit = lsb ? load_word[0] : load_word[FRAME_W-1];
	wire logic [FRAME_W-1:0] done_word = capture ? shifted : shreg;

	// Frame starts.
	wire logic start_m = is_master & ~busy & ~tx_empty & ~mode_fault;
	wire logic start_s = slave_sel & ~busy;
	wire logic start = start_m | start_s;
	wire logic abort = busy & ~(is_master | slave_sel);

	// Read mux.
	wire logic [DATA_W-1:0] status_word = {8'h00, busy, overflow, mode_fault, crc_flag,
		underrun, 1'b0, tx_empty, rx_full};
	wire logic [DATA_W-1:0] read_mux = hit_a ? ctrl_a
		: hit_b ? (ctrl_b & CTRL_B_WRITE_MASK)
		: hit_sts ? status_word
		: hit_data ? DATA_W'(rx_buf)
		: '0;

	wire logic any_error = crc_flag | mode_fault | overflow | underrun;

	spi_clock_divider u_div (
		.clk_i(clk_i),
		.rst_n_i(rst_sync_n),
		.run_i(busy & is_master),
		.code_i(code),
		.tick_o(div_tick)
	);

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rst_meta <= 1'b0;
			rst_sync_n <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	always_ff @(posedge clk_i or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			pin_meta <= 4'hF;
			pin_sync <= 4'hF;
			sck_prev <= 1'b0;
		end
		else
		begin
			pin_meta <= {sck_i, mosi_i, miso_i, cs_i};
			pin_sync <= pin_meta;
			sck_prev <= sck_s;
		end
	end

	// Control registers and data buffers.
	always_ff @(posedge clk_i or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			ctrl_a <= CTRL_A_RESET;
			ctrl_b <= CTRL_B_RESET;
			tx_buf <= FRAME_W'(DATA_RESET);
			rx_buf <= FRAME_W'(DATA_RESET);
			rdata_o <= '0;
		end
		else
		begin
			if (wr_a)
				ctrl_a <= wdata_i;
			if (wr_b)
				ctrl_b <= wdata_i & CTRL_B_WRITE_MASK;
			if (wr_data)
				tx_buf <= wdata_i[FRAME_W-1:0];
			if (frame_end)
				rx_buf <= done_word;
			rdata_o <= rd_i ? read_mux : '0;
		end
	end

	// Status flags; a hardware set wins over a software clear, except tx_empty, where a data write wins over a frame start.
	always_ff @(posedge clk_i or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			tx_empty <= 1'b1;
			rx_full <= 1'b0;
			overflow <= 1'b0;
			mode_fault <= 1'b0;
			crc_flag <= 1'b0;
			underrun <= 1'b0;
			fault_read_armed <= 1'b0;
		end
		else
		begin
			tx_empty <= wr_data ? 1'b0 : (start | tx_empty);
			rx_full <= frame_end | (rx_full & ~rd_data);
			overflow <= (frame_end & rx_full & ~rd_data) | (overflow & ~rd_sts);
			mode_fault <= fault_event | (mode_fault & ~(wr_a & fault_read_armed));
			crc_flag <= crc_error_event_i | (crc_flag & ~(wr_sts & ~wdata_i[STS_CRC]));
			underrun <= tx_underrun_event_i | (underrun & ~rd_sts);
			fault_read_armed <= rd_sts | (fault_read_armed & ~wr_a);
		end
	end

	// Frame engine shared by master and slave roles.
	always_ff @(posedge clk_i or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			busy <= 1'b0;
			shreg <= '0;
			edge_cnt <= '0;
			sck_level <= 1'b0;
			out_bit <= 1'b0;
		end
		else if (start)
		begin
			busy <= 1'b1;
			shreg <= load_word;
			edge_cnt <= '0;
			sck_level <= cpol;
			out_bit <= load_bit;
		end
		else if (abort | frame_end)
		begin
			busy <= 1'b0;
			edge_cnt <= '0;
			sck_level <= cpol;
		end
		else if (edge_any)
		begin
			edge_cnt <= edge_cnt + EDGE_W'(1);
			if (edge_m)
				sck_level <= ~sck_level;
			if (capture)
				shreg <= shifted;
			if (drive)
				out_bit <= tx_bit;
		end
		else if (!busy)
		begin
			sck_level <= cpol;
		end
	end

	// Registered pin drivers and requests.
	always_ff @(posedge clk_i or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			sck_o <= 1'b0;
			sck_oe_o <= 1'b0;
			mosi_o <= 1'b0;
			mosi_oe_o <= 1'b0;
			miso_o <= 1'b0;
			miso_oe_o <= 1'b0;
			cs_o <= 1'b0;
			cs_oe_o <= 1'b0;
			tx_empty_irq_o <= 1'b0;
			rx_full_irq_o <= 1'b0;
			error_irq_o <= 1'b0;
			dma_tx_req_o <= 1'b0;
			dma_rx_req_o <= 1'b0;
		end
		else
		begin
			sck_o <= sck_level;
			sck_oe_o <= is_master;
			mosi_o <= out_bit;
			mosi_oe_o <= is_master;
			miso_o <= out_bit;
			miso_oe_o <= slave_sel;
			cs_o <= 1'b0;
			cs_oe_o <= is_master & ctrl_b.hard_select_output_enable;
			tx_empty_irq_o <= ctrl_b.tx_empty_irq_enable & tx_empty;
			rx_full_irq_o <= ctrl_b.rx_full_irq_enable & rx_full;
			error_irq_o <= ctrl_b.error_irq_enable & any_error;
			dma_tx_req_o <= ctrl_b.dma_tx_request_enable & tx_empty;
			dma_rx_req_o <= ctrl_b.dma_rx_request_enable & rx_full;
		end
	end

endmodule
`default_nettype wire

// *** dv/spi_control_assertions.sv ***
// Port checks for the serial control block.
`timescale 1ns/1ps
`default_nettype none
module spi_control_assertions
	import spi_ctrl_pkg::*;
(
	// Clock, reset and register port.
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [DATA_W-1:0] rdata_o,
	// Pins and requests.
	input wire logic sck_o,
	input wire logic sck_oe_o,
	input wire logic cs_o,
	input wire logic cs_oe_o,
	input wire logic tx_empty_irq_o,
	input wire logic rx_full_irq_o,
	input wire logic error_irq_o,
	input wire logic dma_tx_req_o,
	input wire logic dma_rx_req_o
);
	logic wr_a;
	logic wr_b;
	logic pol;
	logic sck_d;
	logic [9:0] quiet;
	assign wr_a = wr_i && addr_i == CTRL_A_OFFSET;
	assign wr_b = wr_i && addr_i == CTRL_B_OFFSET;
	// Clocks since the serial clock last changed or the first control register was last written.
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			quiet <= 10'h000;
			sck_d <= 1'b0;
			pol <= 1'b0;
		end
		else
		begin
			sck_d <= sck_o;
			pol <= wr_a ? wdata_i[1] : pol;
			quiet <= (wr_a || sck_o != sck_d) ? 10'h000 : quiet + {9'h000, quiet != 10'h3FF};
		end
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	sequence b_read;
		rd_i && addr_i == CTRL_B_OFFSET;
	endsequence
	b_zero_a: assert property (b_read |=> rdata_o[15:9] == 7'h00 && rdata_o[4:3] == 2'h0)
		else $error("reserved bits read set");
	cs_low_a: assert property (cs_oe_o |-> !cs_o)
		else $error("select driven high");
	tx_irq_a: assert property (wr_b && !wdata_i[7] |-> ##[1:3] !tx_empty_irq_o)
		else $error("tx irq not gated");
	rx_irq_a: assert property (wr_b && !wdata_i[6] |-> ##[1:3] !rx_full_irq_o)
		else $error("rx irq not gated");
	err_irq_a: assert property (wr_b && !wdata_i[5] |-> ##[1:3] !error_irq_o)
		else $error("error irq not gated");
	dma_tx_a: assert property (wr_b && !wdata_i[1] |-> ##[1:3] !dma_tx_req_o)
		else $error("tx dma not gated");
	dma_rx_a: assert property (wr_b && !wdata_i[0] |-> ##[1:3] !dma_rx_req_o)
		else $error("rx dma not gated");
	idle_pol_a: assert property (sck_oe_o && quiet > 10'h258 |-> sck_o == pol)
		else $error("clock idle level wrong");
endmodule
`default_nettype wire

// *** dv/spi_far_slave.sv ***
// Behavioural far-side serial slave for master frames.
`timescale 1ns/1ps
`default_nettype none
module spi_far_slave
(
	// Pins.
	input wire logic sck_i,
	input wire logic mosi_i,
	input wire logic select_n_i,
	output logic miso_o,
	// Mode and data.
	input wire logic cpol_i,
	input wire logic cpha_i,
	input wire logic [7:0] tx_byte_i,
	output logic [7:0] rx_byte_o
);
	logic [7:0] sr = 8'h00;
	logic skip = 1'b0;
	initial rx_byte_o = 8'h00;
	// A released line shows the inverse of the held bit so stale data cannot pass.
	assign miso_o = select_n_i ? ~sr[7] : sr[7];
	always @(negedge select_n_i)
	begin
		sr = tx_byte_i;
		skip = cpha_i;
	end
	always @(sck_i)
	begin
		if (!select_n_i && (sck_i ^ cpol_i ^ cpha_i))
			rx_byte_o = {rx_byte_o[6:0], mosi_i};
		else if (!select_n_i && skip)
			skip = 1'b0;
		else if (!select_n_i)
			sr = {sr[6:0], 1'b0};
	end
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// Testbench for the serial control block.
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import spi_ctrl_pkg::*;
();
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [15:0] wdata_i = 16'h0000;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic crc_ev = 1'b0;
	logic und_ev = 1'b0;
	logic [15:0] rdata_o;
	logic sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o, cs_o, cs_oe_o, far_miso;
	logic tx_empty_irq_o, rx_full_irq_o, error_irq_o, dma_tx_req_o, dma_rx_req_o;
	logic [2:0] far_mode = 3'h0;
	logic [7:0] far_tx = 8'h00;
	logic [7:0] far_rx;
	logic [15:0] run = 16'h0000;
	logic [15:0] half = 16'h0000;
	logic sck_q = 1'b0;
	int cyc = 0;
	int n_fail = 0;
	int cmp_count = 0;
	wire logic sck_w = sck_oe_o ? sck_o : 1'b0;
	wire logic mosi_w = mosi_oe_o ? mosi_o : 1'b0;
	wire logic miso_w = miso_oe_o ? miso_o : far_miso;
	wire logic cs_w = cs_oe_o ? cs_o : 1'b1;
	always #25 clk_i = ~clk_i;
	spi_control spi_control_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.crc_error_event_i(crc_ev), .tx_underrun_event_i(und_ev),
		.sck_i(sck_w), .sck_o(sck_o), .sck_oe_o(sck_oe_o),
		.mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o),
		.miso_i(miso_w), .miso_o(miso_o), .miso_oe_o(miso_oe_o),
		.cs_i(cs_w), .cs_o(cs_o), .cs_oe_o(cs_oe_o),
		.tx_empty_irq_o(tx_empty_irq_o), .rx_full_irq_o(rx_full_irq_o),
		.error_irq_o(error_irq_o), .dma_tx_req_o(dma_tx_req_o), .dma_rx_req_o(dma_rx_req_o));
	spi_far_slave spi_far_slave_i (.sck_i(sck_w), .mosi_i(mosi_w), .select_n_i(cs_w),
		.miso_o(far_miso), .cpol_i(far_mode[1]), .cpha_i(far_mode[0]),
		.tx_byte_i(far_tx), .rx_byte_o(far_rx));
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Measures the last serial clock half period in system clocks.
	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		sck_q <= sck_o;
		run <= (sck_o != sck_q) ? 16'h0001 : run + 16'h0001;
		half <= (sck_o != sck_q) ? run : half;
		if (cyc == 60000)
		begin
			n_fail++;
			end_sim();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [15:0] e, input logic [15:0] mk = 16'hFFFF);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(negedge clk_i);
		chk(rdata_o & mk, e & mk);
		@(posedge clk_i);
	endtask
	function automatic logic [7:0] rev(input logic [7:0] v);
		for (int i = 0; i < 8; i++)
			rev[i] = v[7 - i];
	endfunction
	task automatic frame(input logic [3:0] c, input logic [2:0] m, input logic [15:0] mk);
		logic [15:0] a;
		logic [7:0] d;
		int n;
		a = {8'h00, m[2], 1'b1, c[2:0], 1'b1, m[1:0]};
		d = 8'hA5 ^ {5'h00, m};
		n = 0;
		far_mode <= m;
		far_tx <= 8'h3C ^ {m, 5'h00};
		wr(CTRL_A_OFFSET, a);
		rdc(CTRL_A_OFFSET, a);
		wr(CTRL_B_OFFSET, {7'h00, c[3], 8'h45});
		wr(DATA_OFFSET, {8'h00, d});
		while (rx_full_irq_o !== 1'b1 && n < 10000)
		begin
			@(posedge clk_i);
			n++;
		end
		chk({15'h0000, dma_rx_req_o}, 16'h0001);
		rdc(DATA_OFFSET, {8'h00, m[2] ? rev(far_tx) : far_tx}, mk);
		repeat (2) @(posedge clk_i);
		chk({15'h0000, rx_full_irq_o}, 16'h0000);
		chk({8'h00, far_rx}, {8'h00, m[2] ? rev(d) : d});
		chk(half, 16'h0001 << c);
		chk({15'h0000, sck_o}, {15'h0000, m[1]});
		// Leave master mode first, so the lagging select input cannot flag a mode fault.
		wr(CTRL_A_OFFSET, 16'h0000);
		wr(CTRL_B_OFFSET, 16'h0041);
	endtask
	initial
	begin
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rdc(CTRL_A_OFFSET, CTRL_A_RESET);
		rdc(STATUS_OFFSET, 16'h0002);
		rdc(8'h10, 16'h0000);
		wr(CTRL_B_OFFSET, 16'hFFFF);
		rdc(CTRL_B_OFFSET, 16'h01E7);
		chk({14'h0000, tx_empty_irq_o, dma_tx_req_o}, 16'h0003);
		wr(CTRL_B_OFFSET, 16'h0000);
		repeat (2) @(posedge clk_i);
		chk({14'h0000, tx_empty_irq_o, dma_tx_req_o}, 16'h0000);
		wr(CTRL_A_OFFSET, 16'h0240);
		repeat (4) @(posedge clk_i);
		chk({15'h0000, miso_oe_o}, 16'h0001);
		wr(CTRL_A_OFFSET, 16'h0340);
		repeat (4) @(posedge clk_i);
		chk({15'h0000, miso_oe_o}, 16'h0000);
		wr(CTRL_A_OFFSET, 16'h0344);
		rdc(STATUS_OFFSET, 16'h0002);
		wr(CTRL_A_OFFSET, 16'h0244);
		rdc(STATUS_OFFSET, 16'h0022);
		wr(CTRL_A_OFFSET, 16'h0000);
		rdc(STATUS_OFFSET, 16'h0022);
		wr(CTRL_A_OFFSET, 16'h0000);
		wr(CTRL_B_OFFSET, 16'h0020);
		for (int k = 0; k < 2; k++)
		begin
			{und_ev, crc_ev} <= k ? 2'b10 : 2'b01;
			@(posedge clk_i);
			{und_ev, crc_ev} <= 2'b00;
			repeat (3) @(posedge clk_i);
			chk({15'h0000, error_irq_o}, 16'h0001);
			rdc(STATUS_OFFSET, k ? 16'h000A : 16'h0012);
			if (k == 0)
				wr(STATUS_OFFSET, 16'h0000);
			repeat (3) @(posedge clk_i);
			chk({15'h0000, error_irq_o}, 16'h0000);
		end
		frame(4'h2, 3'h0, 16'h00FF);
		frame(4'h2, 3'h1, 16'h00FF);
		frame(4'h2, 3'h2, 16'h00FF);
		frame(4'h8, 3'h3, 16'h00FF);
		frame(4'h9, 3'h4, 16'h00FF);
		frame(4'h0, 3'h0, 16'h0000);
		wr(CTRL_A_OFFSET, 16'h0046);
		repeat (700) @(posedge clk_i);
		chk({14'h0000, sck_oe_o, sck_o}, 16'h0003);
		end_sim();
	end
endmodule
bind spi_control spi_control_assertions chk_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.sck_o(sck_o), .sck_oe_o(sck_oe_o), .cs_o(cs_o), .cs_oe_o(cs_oe_o),
	.tx_empty_irq_o(tx_empty_irq_o), .rx_full_irq_o(rx_full_irq_o),
	.error_irq_o(error_irq_o), .dma_tx_req_o(dma_tx_req_o), .dma_rx_req_o(dma_rx_req_o));
`default_nettype wire
